// File: verification/ifm_host_model.sv
// host controller model: terminal contact levels and serial virtual input levels
`timescale 1ns/10ps
`default_nettype none

module ifm_host_model (
   input wire logic [4:0] term_lvl,
   input wire logic [15:0] virt_lvl,
   output logic [4:0] term_pin,
   output logic [15:0] virt_bit
);
   // contacts are plain levels; the device does its own synchronising
   assign term_pin = term_lvl;
   assign virt_bit = virt_lvl;
endmodule : ifm_host_model
`default_nettype wire

// File: verification/ifm_top_properties.sv
// concurrent checks on the input function mapper ports
`timescale 1ns/10ps
`default_nettype none
`include "ifm_regs.svh"

module ifm_top_properties (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic par_wr_en,
   input wire ifm_pkg::ifm_par_wr_s par_wr,
   input wire logic par_rd_en,
   input wire logic cfg_reload,
   input wire logic par_wr_ack,
   input wire logic par_wr_err,
   input wire logic par_rvalid,
   input wire logic cfg_busy,
   input wire ifm_pkg::ifm_fn_t func_act,
   input wire ifm_pkg::ifm_ana_s ana_set
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   logic [5:0] busy_cnt_r;
   // counts busy cycles so the reload length is checked without a long repetition
   always_ff @(posedge clk_sys) begin
      if (!rst_n) busy_cnt_r <= 6'h00;
      else busy_cnt_r <= cfg_busy ? busy_cnt_r + 6'h01 : 6'h00;
   end

   chk_wr_answer: assert property (par_wr_en |=> par_wr_ack ^ par_wr_err)
      else $error("write got no single answer");
   chk_panel_block: assert property (par_wr_en && !par_wr.serial &&
      par_wr.num inside {[`IFM_PN_VIRT_FIRST:`IFM_PN_VIRT_LAST]} |=> par_wr_err)
      else $error("panel write to virtual assignment accepted");
   chk_code_range: assert property (par_wr_en && par_wr.num inside {[8'h01:8'h1E]} &&
      par_wr.data > 16'h004E |=> par_wr_err && !par_wr_ack)
      else $error("code above 78 accepted");
   chk_bias_range: assert property (par_wr_en && par_wr.num == `IFM_PN_SPD_BIAS &&
      ($signed(par_wr.data) > 2000 || $signed(par_wr.data) < -2000) |=> par_wr_err)
      else $error("speed bias out of range accepted");
   chk_bit_zero: assert property (!func_act[0])
      else $error("code zero shows as active");
   chk_undef_codes: assert property ((func_act & ~`IFM_FN_VALID) == '0)
      else $error("undefined function active");
   chk_busy_len: assert property ($fell(cfg_busy) |-> busy_cnt_r == 6'h1B)
      else $error("reload length wrong");
   chk_reload_start: assert property (cfg_reload && !cfg_busy |=> cfg_busy)
      else $error("reload did not start");
   chk_read_answer: assert property (par_rd_en && !cfg_busy |-> ##2 par_rvalid)
      else $error("read answer missing");
   chk_gain_reset: assert property ($rose(rst_n) |->
      ana_set.spd_gain == 16'h0032 && ana_set.trq_gain == 16'h001E)
      else $error("scale defaults wrong");
endmodule : ifm_top_properties

bind ifm_top ifm_top_properties ifm_top_properties_inst (.clk_sys, .rst_n, .par_wr_en,
   .par_wr, .par_rd_en, .cfg_reload, .par_wr_ack, .par_wr_err, .par_rvalid, .cfg_busy,
   .func_act, .ana_set);
`default_nettype wire

// File: verification/ifm_top_tb.sv
// self-checking bench for the input function mapper
`timescale 1ns/10ps
`default_nettype none
`include "ifm_regs.svh"

module ifm_top_tb;
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   logic [4:0] tv = 5'h00;
   logic [15:0] vv = 16'h0000;
   logic [4:0] term_pin;
   logic [15:0] virt_bit;
   logic par_wr_en = 1'b0;
   ifm_pkg::ifm_par_wr_s par_wr = '0;
   logic par_rd_en = 1'b0;
   logic [7:0] par_rd_num = 8'h00;
   logic cfg_reload = 1'b0;
   logic par_wr_ack, par_wr_err, par_rvalid, cfg_busy;
   logic [15:0] par_rdata;
   ifm_pkg::ifm_fn_t func_act;
   ifm_pkg::ifm_ana_s ana_set;
   int errors = 0;
   int compares = 0;
   logic [7:0] pend [26];
   logic [7:0] act [26];
   logic [7:0] codes [18] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08,
      8'h0A, 8'h0B, 8'h1A, 8'h1B, 8'h1C, 8'h22, 8'h33, 8'h34, 8'h35, 8'h36};
   logic [20:0] pats [4] = '{21'h000000, 21'h1F000F, 21'h0A0005, 21'h15000A};

   initial begin
      forever #25 clk_sys = ~clk_sys;
   end

   ifm_host_model ifm_host_model_inst (.term_lvl(tv), .virt_lvl(vv), .term_pin(term_pin),
      .virt_bit(virt_bit));

   ifm_top ifm_top_inst (.clk_sys(clk_sys), .rst_n(rst_n), .term_pin(term_pin),
      .virt_bit(virt_bit), .par_wr_en(par_wr_en), .par_wr(par_wr), .par_rd_en(par_rd_en),
      .par_rd_num(par_rd_num), .cfg_reload(cfg_reload), .par_wr_ack(par_wr_ack),
      .par_wr_err(par_wr_err), .par_rvalid(par_rvalid), .par_rdata(par_rdata),
      .cfg_busy(cfg_busy), .func_act(func_act), .ana_set(ana_set));

   task automatic summarize();
      $display("checks %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : summarize

   task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("mismatch t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : cmp_word

   task automatic cmp_fn(input logic [78:0] got, input logic [78:0] exp);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("mismatch t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : cmp_fn

   // store index: terminals 0..4, virtual inputs 5..20, slots 21..25
   function automatic int ix(input logic [7:0] n);
      ix = (n < 8'h06) ? n - 1 : (n < 8'h19) ? n - 4 : n - 5;
   endfunction : ix

   function automatic logic [78:0] calc(input logic [4:0] p, input logic [15:0] v);
      logic [78:0] e;
      logic nc;
      logic on;
      e = '0;
      for (int i = 0; i < 26; i++) begin
         nc = act[i] inside {8'h07, 8'h08, 8'h0A, 8'h22};
         if (i < 5) on = nc ? !p[i] : p[i];
         else if (i < 21) on = v[i - 5] && act[i] != 8'h30;
         else on = !nc;
         if (on && act[i] != 8'h00) e[act[i]] = 1'b1;
      end
      calc = e & `IFM_FN_VALID;
   endfunction : calc

   task automatic wr(input logic s, input logic [7:0] n, input logic [15:0] d, input logic ee);
      @(posedge clk_sys);
      par_wr_en <= 1'b1;
      par_wr <= '{serial: s, num: n, data: d};
      @(posedge clk_sys);
      par_wr_en <= 1'b0;
      #1 cmp_word({14'h0000, par_wr_ack, par_wr_err}, {14'h0000, !ee, ee});
      if (!ee && n < 8'h1F) pend[ix(n)] = d[7:0];
   endtask : wr

   task automatic rd(input logic [7:0] n, input logic [15:0] exp);
      @(posedge clk_sys);
      par_rd_en <= 1'b1;
      par_rd_num <= n;
      @(posedge clk_sys);
      par_rd_en <= 1'b0;
      @(posedge clk_sys);
      #1 cmp_word({15'h0, par_rvalid}, 16'h0001);
      cmp_word(par_rdata, exp);
   endtask : rd

   task automatic reload();
      int k;
      @(posedge clk_sys);
      cfg_reload <= 1'b1;
      @(posedge clk_sys);
      cfg_reload <= 1'b0;
      for (k = 0; k < 40; k++) begin
         @(posedge clk_sys);
         #1 if (!cfg_busy) break;
      end
      if (k == 40) begin
         errors++;
         summarize();
      end
      // 27 busy cycles: the first 26 looks after the strobe is taken see it high
      cmp_word(16'(k), 16'h001A);
      act = pend;
   endtask : reload

   task automatic pins(input logic [4:0] p, input logic [15:0] v);
      @(posedge clk_sys);
      tv <= p;
      vv <= v;
      repeat (5) @(posedge clk_sys);
      #1 cmp_fn(func_act, calc(p, v));
   endtask : pins

   initial begin
      foreach (pend[i]) pend[i] = 8'h00;
      pend[0] = 8'h01;
      pend[1] = 8'h0B;
      act = pend;
      repeat (3) @(posedge clk_sys);
      rst_n <= 1'b1;
      for (int n = 1; n < 35; n++) begin
         rd(n[7:0], (n == 1) ? 16'h0001 : (n == 2) ? 16'h000B :
            (n == 31) ? 16'h0032 : (n == 33) ? 16'h001E : 16'h0000);
      end
      pins(5'h03, 16'h0000);
      pins(5'h00, 16'h0000);
      foreach (codes[i]) begin
         wr(1'b1, 8'h09, {8'h00, codes[i]}, 1'b0);
         reload();
         pins(5'h00, 16'h0001);
         pins(5'h00, 16'h0000);
      end
      wr(1'b0, 8'h09, 16'h0002, 1'b1);
      wr(1'b0, 8'h18, 16'h0002, 1'b1);
      wr(1'b1, 8'h1A, 16'h004F, 1'b1);
      wr(1'b1, 8'h1A, 16'h004E, 1'b0);
      rd(8'h1A, 16'h004E);
      wr(1'b1, 8'h06, 16'h0001, 1'b1);
      wr(1'b1, 8'h1F, 16'h03E9, 1'b1);
      wr(1'b1, 8'h1F, 16'hFFF6, 1'b0);
      cmp_word(ana_set.spd_gain, 16'hFFF6);
      wr(1'b1, 8'h21, 16'h0065, 1'b1);
      wr(1'b1, 8'h21, 16'h0009, 1'b1);
      wr(1'b1, 8'h21, 16'h0064, 1'b0);
      cmp_word(ana_set.trq_gain, 16'h0064);
      wr(1'b1, 8'h22, 16'h00C9, 1'b1);
      wr(1'b1, 8'h22, 16'hFF38, 1'b0);
      rd(8'h22, 16'hFF38);
      wr(1'b1, 8'h20, 16'h07D1, 1'b1);
      wr(1'b1, 8'h20, 16'h07D0, 1'b0);
      cmp_word(ana_set.spd_bias, 16'h07D0);
      wr(1'b1, 8'h20, 16'hF830, 1'b0);
      cmp_word(ana_set.spd_bias, 16'hF830);
      // interrupt enable only on a terminal; slots avoid the forbidden codes
      // the panel may still write a terminal assignment
      wr(1'b0, 8'h01, 16'h0007, 1'b0);
      wr(1'b1, 8'h02, 16'h000A, 1'b0);
      wr(1'b1, 8'h03, 16'h0033, 1'b0);
      wr(1'b1, 8'h04, 16'h0002, 1'b0);
      wr(1'b1, 8'h05, 16'h0030, 1'b0);
      wr(1'b1, 8'h0A, 16'h0022, 1'b0);
      wr(1'b1, 8'h0B, 16'h0034, 1'b0);
      wr(1'b1, 8'h0C, 16'h001B, 1'b0);
      wr(1'b1, 8'h1A, 16'h0035, 1'b0);
      wr(1'b1, 8'h1B, 16'h0007, 1'b0);
      wr(1'b1, 8'h1C, 16'h0002, 1'b0);
      wr(1'b1, 8'h1E, 16'h001A, 1'b0);
      pins(5'h1F, 16'h000F);
      reload();
      foreach (pats[i]) pins(pats[i][20:16], pats[i][15:0]);
      summarize();
   end
endmodule : ifm_top_tb
`default_nettype wire

// File: verilog/ifm_func_dec.sv
// function code to one-hot function enable decoder
`timescale 1ns/10ps
`default_nettype none
`include "ifm_regs.svh"

module ifm_func_dec (
   input wire ifm_pkg::ifm_code_t code,
   output logic [78:0] onehot
);
   // undefined codes and code zero select nothing rather than alias
   wire logic [78:0] valid_w = `IFM_FN_VALID;
   wire logic in_range_w = code <= `IFM_CODE_MAX;
   wire logic [78:0] shift_w = {78'h0, 1'b1} << code[6:0];
   wire logic hit_w = in_range_w && valid_w[code[6:0]];

   assign onehot = hit_w ? shift_w : 79'h0;
endmodule : ifm_func_dec
`default_nettype wire

// File: verilog/ifm_pkg.sv
// types shared by the input function mapper
`include "ifm_regs.svh"
package ifm_pkg;
   typedef logic [7:0] ifm_code_t;
   typedef logic [78:0] ifm_fn_t;

   typedef struct packed {
      logic serial;
      logic [7:0] num;
      logic [15:0] data;
   } ifm_par_wr_s;

   typedef struct packed {
      logic [15:0] spd_gain;
      logic [15:0] spd_bias;
      logic [15:0] trq_gain;
      logic [15:0] trq_bias;
   } ifm_ana_s;

   typedef enum logic [1:0] {
      IFM_ST_IDLE = 2'b00,
      IFM_ST_LOAD = 2'b01,
      IFM_ST_LAST = 2'b10
   } ifm_state_e;

   function automatic ifm_code_t ifm_rst_code(input int ix);
      ifm_rst_code = (ix == 0) ? `IFM_RST_TERM1 : (ix == 1) ? `IFM_RST_TERM2 : `IFM_RST_OTHER;
   endfunction : ifm_rst_code
endpackage : ifm_pkg

// File: verilog/ifm_regs.svh
// parameter numbers, reset values, ranges and function codes of the input function mapper
`ifndef IFM_REGS_SVH
`define IFM_REGS_SVH

// parameter numbers as seen on the parameter port
`define IFM_PN_TERM_FIRST 8'h01
`define IFM_PN_TERM_LAST 8'h05
`define IFM_PN_VIRT_FIRST 8'h09
`define IFM_PN_VIRT_LAST 8'h18
`define IFM_PN_SLOT_FIRST 8'h1A
`define IFM_PN_SLOT_LAST 8'h1E
`define IFM_PN_SPD_GAIN 8'h1F
`define IFM_PN_SPD_BIAS 8'h20
`define IFM_PN_TRQ_GAIN 8'h21
`define IFM_PN_TRQ_BIAS 8'h22

// settings store layout: terminals, then virtual inputs, then slots
`define IFM_IX_VIRT 8'h05
`define IFM_IX_SLOT 8'h15
`define IFM_IX_LAST 8'h19

// reset values
`define IFM_RST_TERM1 8'h01
`define IFM_RST_TERM2 8'h0B
`define IFM_RST_OTHER 8'h00
`define IFM_RST_SPD_GAIN 16'h0032
`define IFM_RST_SPD_BIAS 16'h0000
`define IFM_RST_TRQ_GAIN 16'h001E
`define IFM_RST_TRQ_BIAS 16'h0000

// setting ranges: gains in 0.1 V, speed bias in mV, torque bias in 10 mV
`define IFM_CODE_MAX 8'h4E
`define IFM_GAIN_MIN 16'h000A
`define IFM_SPD_GAIN_MAX 16'h03E8
`define IFM_TRQ_GAIN_MAX 16'h0064
`define IFM_SPD_BIAS_MAX 16'h07D0
`define IFM_TRQ_BIAS_MAX 16'h00C8

// function codes
`define IFM_FN_SERVO_ON 8'h01
`define IFM_FN_FORWARD_RUN 8'h02
`define IFM_FN_REVERSE_RUN 8'h03
`define IFM_FN_START_POS 8'h04
`define IFM_FN_HOMING_REQUEST 8'h05
`define IFM_FN_HOME_LIMIT_SWITCH 8'h06
`define IFM_FN_POSITIVE_OVERTRAVEL 8'h07
`define IFM_FN_NEGATIVE_OVERTRAVEL 8'h08
`define IFM_FN_FORCED_STOP 8'h0A
`define IFM_FN_ALARM_RESET 8'h0B
`define IFM_FN_PULSE_INHIBIT 8'h1A
`define IFM_FN_PULSE_RATIO_1 8'h1B
`define IFM_FN_PULSE_RATIO_2 8'h1C
`define IFM_FN_REGEN_OVERHEAT 8'h22
`define IFM_FN_INT_ENABLE 8'h30
`define IFM_FN_SPEED_STEP_BIT_A 8'h33
`define IFM_FN_SPEED_STEP_BIT_B 8'h34
`define IFM_FN_SPEED_STEP_BIT_C 8'h35
`define IFM_FN_FREE_RUN 8'h36

// one bit per defined function code, bit 0 (no function) clear
`define IFM_FN_VALID 79'h6000F6FFF87DBFDB4DFE
`endif

// File: verilog/ifm_set_mem.sv
// stored assignment and always-on settings, registered read port
`timescale 1ns/10ps
`default_nettype none
`include "ifm_regs.svh"

module ifm_set_mem (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic wr_en,
   input wire logic [4:0] wr_ix,
   input wire ifm_pkg::ifm_code_t wr_data,
   input wire logic [4:0] rd_ix,
   output var ifm_pkg::ifm_code_t rd_data
);
   ifm_pkg::ifm_code_t mem_r [0:25];

   genvar g;
   generate
      for (g = 0; g < 26; g++) begin : g_ent
         always_ff @(posedge clk_sys) begin
            if (!rst_n) begin
               mem_r[g] <= ifm_pkg::ifm_rst_code(g);
            end else if (wr_en && (wr_ix == 5'(g))) begin
               mem_r[g] <= wr_data;
            end
         end
      end
   endgenerate

   wire logic rd_in_w = {3'h0, rd_ix} <= `IFM_IX_LAST;

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         rd_data <= 8'h00;
      end else begin
         rd_data <= rd_in_w ? mem_r[rd_ix] : 8'h00;
      end
   end
endmodule : ifm_set_mem
`default_nettype wire

// File: verilog/ifm_top.sv
// input function mapper: terminals, virtual inputs and always-on slots onto function enables
`timescale 1ns/10ps
`default_nettype none
`include "ifm_regs.svh"

module ifm_top (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic [4:0] term_pin,
   input wire logic [15:0] virt_bit,
   input wire logic par_wr_en,
   input wire ifm_pkg::ifm_par_wr_s par_wr,
   input wire logic par_rd_en,
   input wire logic [7:0] par_rd_num,
   input wire logic cfg_reload,
   output var logic par_wr_ack,
   output var logic par_wr_err,
   output var logic par_rvalid,
   output var logic [15:0] par_rdata,
   output var logic cfg_busy,
   output var ifm_pkg::ifm_fn_t func_act,
   output var ifm_pkg::ifm_ana_s ana_set
);
   localparam int NSRC = 26;
   localparam int NTERM = 5;
   localparam int NVIRT = 16;
   localparam logic [4:0] LD_LAST = 5'h19;

   // normally closed on a hardware terminal
   function automatic logic ifm_is_nc(input ifm_pkg::ifm_code_t code);
      ifm_is_nc = (code == `IFM_FN_POSITIVE_OVERTRAVEL) ||
                  (code == `IFM_FN_NEGATIVE_OVERTRAVEL) ||
                  (code == `IFM_FN_FORCED_STOP) ||
                  (code == `IFM_FN_REGEN_OVERHEAT);
   endfunction : ifm_is_nc

   // parameter number to store index, bit 5 marks a store-backed number
   function automatic logic [5:0] ifm_map(input logic [7:0] num);
      logic [7:0] off;
      off = 8'h00;
      ifm_map = 6'h00;
      if ((num >= `IFM_PN_TERM_FIRST) && (num <= `IFM_PN_TERM_LAST)) begin
         off = num - `IFM_PN_TERM_FIRST;
         ifm_map = {1'b1, off[4:0]};
      end else if ((num >= `IFM_PN_VIRT_FIRST) && (num <= `IFM_PN_VIRT_LAST)) begin
         off = num - `IFM_PN_VIRT_FIRST + `IFM_IX_VIRT;
         ifm_map = {1'b1, off[4:0]};
      end else if ((num >= `IFM_PN_SLOT_FIRST) && (num <= `IFM_PN_SLOT_LAST)) begin
         off = num - `IFM_PN_SLOT_FIRST + `IFM_IX_SLOT;
         ifm_map = {1'b1, off[4:0]};
      end
   endfunction : ifm_map

   // signed window check
   function automatic logic ifm_in_span(
      input logic [15:0] val,
      input logic [15:0] lo,
      input logic [15:0] hi
   );
      ifm_in_span = ($signed(val) >= $signed(lo)) && ($signed(val) <= $signed(hi));
   endfunction : ifm_in_span

   // gains may carry either sign, magnitude within min..max
   function automatic logic ifm_gain_ok(
      input logic [15:0] val,
      input logic [15:0] hi
   );
      ifm_gain_ok = ifm_in_span(val, `IFM_GAIN_MIN, hi) ||
                    ifm_in_span(val, 16'h0000 - hi, 16'h0000 - `IFM_GAIN_MIN);
   endfunction : ifm_gain_ok

   // ------------------------------------------------------------
   // terminal pins arrive from outside: two-stage synchroniser
   // ------------------------------------------------------------
   logic [4:0] term_meta_r;
   logic [4:0] term_sync_r;

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         term_meta_r <= 5'h00;
         term_sync_r <= 5'h00;
      end else begin
         term_meta_r <= term_pin;
         term_sync_r <= term_meta_r;
      end
   end

   // ------------------------------------------------------------
   // reload sequencer state
   // ------------------------------------------------------------
   ifm_pkg::ifm_state_e st_r;
   ifm_pkg::ifm_state_e st_nxt;
   logic [4:0] ld_ix_r;
   logic [4:0] ld_ix_nxt;
   logic cap_r;
   logic [4:0] cap_ix_r;
   ifm_pkg::ifm_code_t mem_rd_w;

   // ------------------------------------------------------------
   // parameter writes
   // ------------------------------------------------------------
   wire logic [5:0] wr_map_w = ifm_map(par_wr.num);
   wire logic wr_store_w = wr_map_w[5];
   wire logic [4:0] wr_ix_w = wr_map_w[4:0];
   wire logic [7:0] wr_ix8_w = {3'h0, wr_ix_w};
   wire logic wr_is_virt_w = wr_store_w && (wr_ix8_w >= `IFM_IX_VIRT) &&
                             (wr_ix8_w < `IFM_IX_SLOT);
   // the front panel may not touch the virtual input assignments
   wire logic wr_panel_block_w = wr_is_virt_w && !par_wr.serial;
   wire logic wr_code_bad_w = par_wr.data > {8'h00, `IFM_CODE_MAX};
   wire logic wr_store_ok_w = par_wr_en && wr_store_w && !wr_panel_block_w && !wr_code_bad_w;

   wire logic wr_sg_w = par_wr.num == `IFM_PN_SPD_GAIN;
   wire logic wr_sb_w = par_wr.num == `IFM_PN_SPD_BIAS;
   wire logic wr_tg_w = par_wr.num == `IFM_PN_TRQ_GAIN;
   wire logic wr_tb_w = par_wr.num == `IFM_PN_TRQ_BIAS;

   wire logic sg_ok_w = ifm_gain_ok(par_wr.data, `IFM_SPD_GAIN_MAX);
   wire logic tg_ok_w = ifm_gain_ok(par_wr.data, `IFM_TRQ_GAIN_MAX);
   wire logic sb_ok_w = ifm_in_span(par_wr.data, 16'h0000 - `IFM_SPD_BIAS_MAX,
                                    `IFM_SPD_BIAS_MAX);
   wire logic tb_ok_w = ifm_in_span(par_wr.data, 16'h0000 - `IFM_TRQ_BIAS_MAX,
                                    `IFM_TRQ_BIAS_MAX);

   wire logic sg_wr_w = par_wr_en && wr_sg_w && sg_ok_w;
   wire logic sb_wr_w = par_wr_en && wr_sb_w && sb_ok_w;
   wire logic tg_wr_w = par_wr_en && wr_tg_w && tg_ok_w;
   wire logic tb_wr_w = par_wr_en && wr_tb_w && tb_ok_w;
   wire logic wr_ok_w = wr_store_ok_w || sg_wr_w || sb_wr_w || tg_wr_w || tb_wr_w;

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         par_wr_ack <= 1'b0;
         par_wr_err <= 1'b0;
      end else begin
         par_wr_ack <= par_wr_en && wr_ok_w;
         par_wr_err <= par_wr_en && !wr_ok_w;
      end
   end

   // scale and offset act at once, unlike the assignments
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         ana_set.spd_gain <= `IFM_RST_SPD_GAIN;
         ana_set.spd_bias <= `IFM_RST_SPD_BIAS;
         ana_set.trq_gain <= `IFM_RST_TRQ_GAIN;
         ana_set.trq_bias <= `IFM_RST_TRQ_BIAS;
      end else begin
         if (sg_wr_w) begin
            ana_set.spd_gain <= par_wr.data;
         end
         if (sb_wr_w) begin
            ana_set.spd_bias <= par_wr.data;
         end
         if (tg_wr_w) begin
            ana_set.trq_gain <= par_wr.data;
         end
         if (tb_wr_w) begin
            ana_set.trq_bias <= par_wr.data;
         end
      end
   end

   // ------------------------------------------------------------
   // parameter reads: two edges to the answer, refused while busy
   // ------------------------------------------------------------
   wire logic [5:0] rd_map_w = ifm_map(par_rd_num);
   wire logic rd_take_w = par_rd_en && !cfg_busy;
   wire logic [4:0] mem_rd_ix_w = cfg_busy ? ld_ix_r : rd_map_w[4:0];

   logic rd_pend_r;
   logic rd_store_r;
   logic [7:0] rd_num_r;

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         rd_pend_r <= 1'b0;
         rd_store_r <= 1'b0;
         rd_num_r <= 8'h00;
      end else begin
         rd_pend_r <= rd_take_w;
         rd_store_r <= rd_map_w[5];
         rd_num_r <= par_rd_num;
      end
   end

   wire logic [15:0] rd_ana_w =
      (rd_num_r == `IFM_PN_SPD_GAIN) ? ana_set.spd_gain :
      (rd_num_r == `IFM_PN_SPD_BIAS) ? ana_set.spd_bias :
      (rd_num_r == `IFM_PN_TRQ_GAIN) ? ana_set.trq_gain :
      (rd_num_r == `IFM_PN_TRQ_BIAS) ? ana_set.trq_bias : 16'h0000;
   wire logic [15:0] rd_data_w = rd_store_r ? {8'h00, mem_rd_w} : rd_ana_w;

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         par_rvalid <= 1'b0;
         par_rdata <= 16'h0000;
      end else begin
         par_rvalid <= rd_pend_r;
         par_rdata <= rd_pend_r ? rd_data_w : 16'h0000;
      end
   end

   // stored settings; what is stored here is not yet in force
   ifm_set_mem u_mem (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .wr_en(wr_store_ok_w),
      .wr_ix(wr_ix_w),
      .wr_data(par_wr.data[7:0]),
      .rd_ix(mem_rd_ix_w),
      .rd_data(mem_rd_w)
   );

   // ------------------------------------------------------------
   // reload: copy the store into the active set, as at power-up
   // ------------------------------------------------------------
   always_comb begin
      st_nxt = st_r;
      ld_ix_nxt = 5'h00;
      unique case (st_r)
         ifm_pkg::IFM_ST_IDLE: begin
            if (cfg_reload) begin
               st_nxt = ifm_pkg::IFM_ST_LOAD;
            end
         end
         ifm_pkg::IFM_ST_LOAD: begin
            ld_ix_nxt = ld_ix_r + 5'h01;
            if (ld_ix_r == LD_LAST) begin
               st_nxt = ifm_pkg::IFM_ST_LAST;
               ld_ix_nxt = 5'h00;
            end
         end
         ifm_pkg::IFM_ST_LAST: begin
            st_nxt = ifm_pkg::IFM_ST_IDLE;
         end
         default: begin
            st_nxt = ifm_pkg::IFM_ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         st_r <= ifm_pkg::IFM_ST_IDLE;
         ld_ix_r <= 5'h00;
         cap_r <= 1'b0;
         cap_ix_r <= 5'h00;
         cfg_busy <= 1'b0;
      end else begin
         st_r <= st_nxt;
         ld_ix_r <= ld_ix_nxt;
         cap_r <= st_r == ifm_pkg::IFM_ST_LOAD;
         cap_ix_r <= ld_ix_r;
         cfg_busy <= st_nxt != ifm_pkg::IFM_ST_IDLE;
      end
   end

   // ------------------------------------------------------------
   // sources: active code, decode, polarity, or-combine
   // ------------------------------------------------------------
   ifm_pkg::ifm_code_t act_r [0:NSRC-1];
   ifm_pkg::ifm_fn_t acc_w [0:NSRC];

   assign acc_w[0] = 79'h0;

   genvar g;
   generate
      for (g = 0; g < NSRC; g++) begin : g_src
         ifm_pkg::ifm_fn_t oh_w;
         logic on_w;

         always_ff @(posedge clk_sys) begin
            if (!rst_n) begin
               act_r[g] <= ifm_pkg::ifm_rst_code(g);
            end else if (cap_r && (cap_ix_r == 5'(g))) begin
               act_r[g] <= mem_rd_w;
            end
         end

         ifm_func_dec u_dec (
            .code(act_r[g]),
            .onehot(oh_w)
         );

         if (g < NTERM) begin : g_term
            // an open NC contact means the function is active
            assign on_w = term_sync_r[g] ^ ifm_is_nc(act_r[g]);
         end else if (g < NTERM + NVIRT) begin : g_virt
            // interrupt-input enable has no meaning off a terminal
            assign on_w = virt_bit[g - NTERM] &&
                          (act_r[g] != `IFM_FN_INT_ENABLE);
         end else begin : g_slot
            // NO forced on, NC held in its non-fault state
            assign on_w = !ifm_is_nc(act_r[g]);
         end

         // a slot and a terminal may share a function
         assign acc_w[g + 1] = acc_w[g] | (on_w ? oh_w : 79'h0);
      end
   endgenerate

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         func_act <= 79'h0;
      end else begin
         func_act <= acc_w[NSRC];
      end
   end
endmodule : ifm_top
`default_nettype wire
